// >>> rtl/wdrt_timer.sv
/*
  Watchdog reset timer: protection lock, run control, counter control and
  system reset generation.
  Assumes control writes arrive as one-cycle strobes synchronous to clk and
  that wdtTick pulses once per watchdog operating clock period; the clock
  controller drops wdtTick when the selected source stops.
*/
// Function
// - Ten-bit up counter advances on watchdog clock
// - Counter overflow asserts system reset only
// - Never produce a non-maskable interrupt
// - Writing one to clear bit zeroes counter
// - Run code other than 0xa starts counting
// - Key other than 0x0096 re-locks control bits
// - Clear starts fresh period; otherwise reset follows
// - Counting continues during CPU HALT mode
// - Counting halts when clock source stops
`timescale 1ns/1ps
module wdrt_timer
  import wdrt_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  // Watchdog operating clock, one pulse per period.
  input wire logic wdtTick,
  // Control write of the counter clear bit and the run field.
  input wire logic ctlWrEn,
  input wire logic ctlClearIn,
  input wire logic [3:0] ctlRunIn,
  // Write of the protection key field.
  input wire logic keyWrEn,
  input wire logic [15:0] keyIn,
  // Results.
  output logic sysResetOut,
  output logic nmiOut,
  output logic runningOut,
  output logic protectOnOut,
  output logic [CNT_WIDTH-1:0] countOut
);

  wdrt_state_type state_q;
  wdrt_state_type state_d;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic protect_q;
  logic protect_d;
  logic [2:0] rstCnt_q;
  logic [2:0] rstCnt_d;
  logic sysReset_q;
  logic sysReset_d;
  logic running_q;
  logic running_d;
  logic nmi_q;
  logic ctlAccepted;
  logic clearReq;
  logic running;
  logic cntEnable;
  logic cntClear;
  logic overflow;

  // Control writes are ignored during the reset pulse; the pulse ends as a fresh
  // start anyway, so nothing software could set would survive it.
  assign ctlAccepted = ctlWrEn && !protect_q && (state_q != WDRT_RESET);
  assign clearReq = ctlAccepted && ctlClearIn;
  assign running = (run_q != RUN_STOP);
  // No CPU mode enters here: HALT leaves ticks running, a stopped source
  // in SLEEP removes them.
  assign cntEnable =
    (state_q == WDRT_COUNT) && running && wdtTick;
  assign cntClear = clearReq || (state_q == WDRT_RESET);

  wdrt_counter u_counter (
    .clk(clk),
    .srst(srst),
    .clkEn(clkEn),
    .clear(cntClear),
    .count(cntEnable),
    .value(countOut),
    .overflow(overflow)
  );

  always_comb
  begin
    protect_d = protect_q;
    run_d = run_q;
    state_d = state_q;
    rstCnt_d = rstCnt_q;
    if (keyWrEn)
    begin
      protect_d = (keyIn != UNLOCK_KEY);
    end
    if (ctlAccepted)
    begin
      run_d = ctlRunIn;
    end
    case (state_q)
      WDRT_STOP:
      begin
        if (running)
        begin
          state_d = WDRT_COUNT;
        end
      end
      WDRT_COUNT:
      begin
        if (!running)
        begin
          state_d = WDRT_STOP;
        end
        else if (overflow && !clearReq)
        begin
          state_d = WDRT_RESET;
          rstCnt_d = SYSRST_CNT_RESET;
        end
      end
      WDRT_RESET:
      begin
        rstCnt_d = rstCnt_q + 3'h1;
        if (rstCnt_q == SYSRST_CYCLES - 3'h1)
        begin
          // The pulse resets the system, so the timer comes back as after
          // power-up: stopped and locked.
          state_d = WDRT_STOP;
          run_d = RUN_RESET;
          protect_d = LOCK_RESET;
          rstCnt_d = SYSRST_CNT_RESET;
        end
      end
      default:
      begin
        state_d = WDRT_STOP;
      end
    endcase
    sysReset_d = (state_d == WDRT_RESET);
    running_d = (run_d != RUN_STOP);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= WDRT_STOP;
      run_q <= RUN_RESET;
      protect_q <= LOCK_RESET;
      rstCnt_q <= SYSRST_CNT_RESET;
      sysReset_q <= 1'b0;
      running_q <= 1'b0;
      nmi_q <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      run_q <= run_d;
      protect_q <= protect_d;
      rstCnt_q <= rstCnt_d;
      sysReset_q <= sysReset_d;
      running_q <= running_d;
      nmi_q <= 1'b0;
    end
  end

  assign sysResetOut = sysReset_q;
  assign nmiOut = nmi_q;
  assign runningOut = running_q;
  assign protectOnOut = protect_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_noNmi;
    !nmiOut;
  endproperty
  a_noNmi: assert property (p_noNmi)
    else $error("NMI output went high");

  property p_overflowReset;
    (clkEn && state_q == WDRT_COUNT && running && overflow && !clearReq)
      |=> (sysResetOut && state_q == WDRT_RESET);
  endproperty
  a_overflowReset: assert property (p_overflowReset)
    else $error("Overflow did not raise the system reset");

  property p_clearZero;
    (clkEn && clearReq) |=> (countOut == CNT_RESET);
  endproperty
  a_clearZero: assert property (p_clearZero)
    else $error("Counter clear did not zero the counter");

  property p_start;
    (clkEn && ctlAccepted && ctlRunIn != RUN_STOP) |=> runningOut;
  endproperty
  a_start: assert property (p_start)
    else $error("Run code did not start the watchdog");

  property p_relock;
    (clkEn && keyWrEn && keyIn != UNLOCK_KEY && !srst)
      |=> protectOnOut;
  endproperty
  a_relock: assert property (p_relock)
    else $error("Key write did not restore protection");

  property p_lockedRun;
    (clkEn && protect_q && state_q != WDRT_RESET) |=> $stable(run_q);
  endproperty
  a_lockedRun: assert property (p_lockedRun)
    else $error("Run field changed while protected");

  property p_freshPeriod;
    (clkEn && clearReq && state_q == WDRT_COUNT) |=> !sysResetOut;
  endproperty
  a_freshPeriod: assert property (p_freshPeriod)
    else $error("Reset raised despite a timely clear");

  property p_advance;
    (clkEn && cntEnable && !clearReq)
      |=> (countOut == CNT_WIDTH'($past(countOut) + CNT_ONE));
  endproperty
  a_advance: assert property (p_advance)
    else $error("Counter did not advance on a tick");

  property p_noTickHold;
    (clkEn && !wdtTick && !clearReq && state_q != WDRT_RESET)
      |=> $stable(countOut);
  endproperty
  a_noTickHold: assert property (p_noTickHold)
    else $error("Counter moved without a watchdog clock tick");

  property p_stopped;
    (run_q == RUN_STOP && $past(run_q) == RUN_STOP)
      |-> (state_q == WDRT_STOP && !sysResetOut);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("Timer active while the run field says stop");

endmodule

// >>> rtl/wdrt_pkg.sv
/*
  Constants shared by the watchdog reset timer: run codes, protection key,
  counter width, state encoding and the length of the reset pulse.
  Assumes a single 50 MHz system clock.
*/
package wdrt_pkg;

  // Clock and time figures.
  localparam int CLK_PERIOD_NS = 20;
  localparam int SYSRST_PULSE_NS = 80;
  localparam int SYSRST_CYCLES_INT =
    (SYSRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SYSRST_CYCLES = 3'(SYSRST_CYCLES_INT);
  localparam logic [2:0] SYSRST_CNT_RESET = 3'h0;

  // Counter.
  localparam int CNT_WIDTH = 10;
  localparam logic [9:0] CNT_RESET = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  localparam logic [9:0] CNT_ONE = 10'h001;

  // Run control field: this one code stops the counter.
  localparam logic [3:0] RUN_STOP = 4'ha;
  localparam logic [3:0] RUN_RESET = 4'ha;

  // Protection key: only this value unlocks the protected control bits.
  localparam logic [15:0] UNLOCK_KEY = 16'h0096;
  localparam logic LOCK_RESET = 1'b1;

  typedef enum logic [1:0] {
    WDRT_STOP = 2'b00,
    WDRT_COUNT = 2'b01,
    WDRT_RESET = 2'b11
  } wdrt_state_type;

endpackage

// >>> rtl/wdrt_counter.sv
/*
  Ten-bit watchdog up counter with a synchronous clear and a one-cycle
  overflow flag. Assumes its caller gates counting with the operating
  clock tick; the clock enable freezes the counter here.
*/
`timescale 1ns/1ps
module wdrt_counter
  import wdrt_pkg::*;
(
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  // Control.
  input wire logic clear,
  input wire logic count,
  // Status.
  output logic [CNT_WIDTH-1:0] value,
  output logic overflow
);

  logic [CNT_WIDTH-1:0] value_q;
  logic [CNT_WIDTH-1:0] value_d;
  logic overflow_q;
  logic overflow_d;

  // A clear in the same cycle as the last tick wins, so a timely clear
  // never lets the overflow through.
  always_comb
  begin
    value_d = value_q;
    overflow_d = 1'b0;
    if (clear)
    begin
      value_d = CNT_RESET;
    end
    else if (count)
    begin
      value_d = value_q + CNT_ONE;
      overflow_d = (value_q == CNT_MAX);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      value_q <= CNT_RESET;
      overflow_q <= 1'b0;
    end
    else if (clkEn)
    begin
      value_q <= value_d;
      overflow_q <= overflow_d;
    end
  end

  assign value = value_q;
  assign overflow = overflow_q;

endmodule

// >>> verification/watchdog_reset_timer_test.sv
/*
  Self-checking bench for the watchdog reset timer.
  Assumes the design package is compiled first; inputs change on falling
  edges and every wait is a fixed or bounded number of cycles.
*/
`timescale 1ns/1ps
module watchdog_reset_timer_test;
  import wdrt_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clkEn = 1'b1;
  logic wdtTick = 1'b0;
  logic ctlWrEn = 1'b0;
  logic ctlClearIn = 1'b0;
  logic [3:0] ctlRunIn = 4'ha;
  logic keyWrEn = 1'b0;
  logic [15:0] keyIn = 16'h0000;
  logic sysResetOut, nmiOut, runningOut, protectOnOut;
  logic [CNT_WIDTH-1:0] countOut;
  int nFail = 0;
  int checked = 0;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin nFail++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end

  wdrt_timer u_dut (.clk(clk), .srst(srst), .clkEn(clkEn),
    .wdtTick(wdtTick), .ctlWrEn(ctlWrEn), .ctlClearIn(ctlClearIn),
    .ctlRunIn(ctlRunIn), .keyWrEn(keyWrEn), .keyIn(keyIn),
    .sysResetOut(sysResetOut), .nmiOut(nmiOut), .runningOut(runningOut),
    .protectOnOut(protectOnOut), .countOut(countOut));

  always #10 clk = ~clk;

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task ctlWr(input logic clr, input logic [3:0] run);
    ctlWrEn = 1'b1;
    ctlClearIn = clr;
    ctlRunIn = run;
    cyc(1);
    ctlWrEn = 1'b0;
    ctlClearIn = 1'b0;
  endtask

  task keyWr(input logic [15:0] k);
    keyWrEn = 1'b1;
    keyIn = k;
    cyc(1);
    keyWrEn = 1'b0;
  endtask

  // Holding the tick high for n cycles gives n operating clock periods.
  task ticks(input int n);
    wdtTick = 1'b1;
    cyc(n);
    wdtTick = 1'b0;
  endtask

  task wrapUp;
    $display("comparisons %0d, mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task scnStartup;
    `CHK(protectOnOut, 1'b1)
    `CHK(runningOut, 1'b0)
    `CHK(nmiOut, 1'b0)
    keyWr(16'h0096);
    `CHK(protectOnOut, 1'b0)
    ctlWr(1'b1, 4'h0);
    `CHK(runningOut, 1'b1)
    cyc(1);
    ticks(5);
    `CHK(countOut, 10'h005)
  endtask

  task scnLockAndSleep;
    keyWr(16'h1234);
    `CHK(protectOnOut, 1'b1)
    ctlWr(1'b1, 4'ha);
    `CHK(countOut, 10'h005)
    `CHK(runningOut, 1'b1)
    cyc(4);
    `CHK(countOut, 10'h005)
  endtask

  task scnClearStop;
    keyWr(16'h0096);
    ctlWr(1'b1, 4'h3);
    `CHK(countOut, 10'h000)
    cyc(1);
    ticks(3);
    `CHK(countOut, 10'h003)
    ctlWr(1'b0, 4'ha);
    `CHK(runningOut, 1'b0)
    cyc(1);
    ticks(1100);
    `CHK(countOut, 10'h003)
    `CHK(sysResetOut, 1'b0)
  endtask

  // Every run code is written; the last one leaves the timer running.
  task scnOverflow;
    int n;
    for (int r = 0; r < 16; r++)
    begin
      ctlWr(1'b0, 4'(r));
      `CHK(runningOut, (4'(r) != 4'ha))
      cyc(1);
    end
    ctlWr(1'b1, 4'hf);
    cyc(1);
    ticks(1024);
    `CHK(countOut, 10'h000)
    `CHK(sysResetOut, 1'b0)
    cyc(1);
    n = 0;
    while (sysResetOut === 1'b1 && n < 10)
    begin
      `CHK(nmiOut, 1'b0)
      n++;
      cyc(1);
    end
    `CHK(n, 4)
    if (n >= 10)
      wrapUp();
    `CHK(runningOut, 1'b0)
    `CHK(protectOnOut, 1'b1)
  endtask

  // A clear on the overflow flag cycle wins; then freeze and a mid-run reset.
  task scnLateClear;
    keyWr(16'h0096);
    ctlWr(1'b1, 4'h5);
    cyc(1);
    ticks(1024);
    ctlWr(1'b1, 4'h5);
    `CHK(sysResetOut, 1'b0)
    `CHK(countOut, 10'h000)
    cyc(2);
    `CHK(sysResetOut, 1'b0)
    ticks(2);
    clkEn = 1'b0;
    cyc(1);
    ticks(3);
    `CHK(countOut, 10'h002)
    clkEn = 1'b1;
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(1);
    `CHK(protectOnOut, 1'b1)
    `CHK(runningOut, 1'b0)
    `CHK(countOut, 10'h000)
  endtask

  initial
  begin
    cyc(8);
    srst = 1'b0;
    cyc(1);
    scnStartup();
    scnLockAndSleep();
    scnClearStop();
    scnOverflow();
    scnLateClear();
    wrapUp();
  end
endmodule
